// file: hw/rapr_defs.vh
// Constants for the row activate / precharge / refresh host controller.
// Assumes a single 100 MHz clock and an AXI4-Lite register port.
// Functional notes
// - With finite limit, activates per row are capped within activate window; controller only reports the limit to software.
// - Activate opens one row chosen by bank group, bank and row address.
// - Row stays open until precharge; precharge before activating another row.
// - Activate spacing short across bank groups, long within one group.
// - No fifth activate inside the four-activate window.
// - Precharge closes one or all banks; activate waits row precharge time.
// - Idle bank must be activated before any read or write.
// - Access to another bank allowed while one bank auto-precharges.
// - All banks idle for row precharge time before refresh.
// - Only deselects until refresh cycle time has elapsed.
// - Average one refresh per interval; postpone up to 8, 16 or 32.
// - Gap between refreshes at most 9, 17 or 33 intervals; code holds a due refresh until the host closes all banks.
// - Up to 8, 16 or 32 pull-ins; extra ones earn nothing.
// - At most 16 refreshes within two intervals; code limits only owed and pulled-in counts, not refreshes per window.
`ifndef RAPR_DEFS_VH
`define RAPR_DEFS_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define RAPR_REG_CTRL      8'h00
`define RAPR_REG_CMD       8'h04
`define RAPR_REG_ROW       8'h08
`define RAPR_REG_STATUS    8'h0C
`define RAPR_REG_MAC       8'h10
`define RAPR_REG_OPEN      8'h14

// ****************************************************************
// Command codes written to the command register
// ****************************************************************
`define RAPR_OP_ACT        3'h1
`define RAPR_OP_PRE        3'h2
`define RAPR_OP_PREA       3'h3
`define RAPR_OP_RD         3'h4
`define RAPR_OP_WR         3'h5
`define RAPR_OP_REF        3'h6

// ****************************************************************
// Refresh-rate mode codes
// ****************************************************************
`define RAPR_FGR_1X        3'h0
`define RAPR_FGR_2X        3'h1
`define RAPR_FGR_4X        3'h2
`define RAPR_FGR_OTF2      3'h5
`define RAPR_FGR_OTF4      3'h6

// ****************************************************************
// Activate-limit codes and timing in cycles of 10 ns
// ****************************************************************
`define RAPR_MAC_UNLIM     4'h8
`define RAPR_MAC_UNTESTED  4'h0
`define RAPR_T_RRDS        8'h04
`define RAPR_T_RRDL        8'h06
`define RAPR_T_FAW         8'h15
`define RAPR_T_RP          8'h0E
`define RAPR_T_RFC         16'h0023
`define RAPR_T_REFI        16'h030C
`define RAPR_POST_1X       6'h08
`define RAPR_OK            2'h0
`define RAPR_SLVERR        2'h2

`endif

// file: hw/rapr_bank_timer.v
// Per-bank open/idle tracking and precharge timer for the host.
// Assumes one command per cycle, strobed by the main controller.
`timescale 1ns/1ps
module rapr_bank_timer #(
  parameter NB  = 8,
  parameter TRP = 8
) (
  input  wire          clk_i,
  input  wire          srst_i,
  input  wire          act_i,
  input  wire          pre_i,
  input  wire          prea_i,
  input  wire          ref_i,
  input  wire [2:0]    bank_i,
  output wire [NB-1:0] open_o,
  output wire [NB-1:0] ready_o
);
  // ****************************************************************
  // Per-bank state
  // ****************************************************************
  // One-hot bank select, so each bank compares one bit instead of a genvar slice
  wire [NB-1:0] sel_oh = {{(NB-1){1'b0}}, 1'b1} << bank_i;
  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1) begin : g_bank
      reg       open;
      reg [7:0] cnt;
      wire      hit = sel_oh[g];
      // Precharge restarts timer even on idle bank
      always @(posedge clk_i) begin
        if (srst_i) begin
          open <= 1'b0;
          cnt  <= 8'h00;
        end else if (act_i && hit) begin
          open <= 1'b1;
        end else if (prea_i || (pre_i && hit)) begin
          open <= 1'b0;
          cnt  <= TRP[7:0];
        end else if (ref_i) begin
          open <= 1'b0;
        end else if (cnt != 8'h00) begin
          cnt  <= cnt - 8'h01;
        end
      end
      assign open_o[g]  = open;
      assign ready_o[g] = (cnt == 8'h00);
    end
  endgenerate
endmodule // rapr_bank_timer

// file: hw/rapr_ctrl.v
// Host controller driving row activate, precharge and refresh commands.
// Assumes an AXI4-Lite master and a device sampling on rising clk_i.
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
`include "rapr_defs.vh"
module rapr_ctrl #(
  parameter T_RRDS = 4,
  parameter T_RRDL = 6,
  parameter T_FAW  = 21,
  parameter T_RP   = 14,
  parameter T_RFC  = 35,
  parameter T_REFI = 780
) (
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire [7:0]  s_awaddr_i,
  input  wire        s_awvalid_i,
  output reg         s_awready_o,
  input  wire [31:0] s_wdata_i,
  input  wire [3:0]  s_wstrb_i,
  input  wire        s_wvalid_i,
  output reg         s_wready_o,
  output reg  [1:0]  s_bresp_o,
  output reg         s_bvalid_o,
  input  wire        s_bready_i,
  input  wire [7:0]  s_araddr_i,
  input  wire        s_arvalid_i,
  output reg         s_arready_o,
  output reg  [31:0] s_rdata_o,
  output reg  [1:0]  s_rresp_o,
  output reg         s_rvalid_o,
  input  wire        s_rready_i,
  input  wire [7:0]  mac_code_i,
  output reg         cs_n_o,
  output reg         act_n_o,
  output reg         ras_n_o,
  output reg         cas_n_o,
  output reg         we_n_o,
  output reg  [1:0]  bg_o,
  output reg  [1:0]  ba_o,
  output reg  [17:0] addr_o
);
  // ****************************************************************
  // Registers and state
  // ****************************************************************
  localparam S_IDLE = 3'b001;
  localparam S_WAIT = 3'b010;
  localparam S_RFC  = 3'b100;
  reg  [2:0]  state;
  reg  [2:0]  fgr_mode;
  reg         auto_ref;
  reg  [31:0] cmd_reg;
  reg         cmd_pend;
  reg  [17:0] row_reg;
  reg  [7:0]  mac_reg;
  reg  [7:0]  rrd_cnt;
  reg  [1:0]  last_bg;
  reg  [7:0]  faw_cnt [0:3];
  reg  [1:0]  faw_ptr;
  reg  [15:0] rfc_cnt;
  reg  [15:0] refi_cnt;
  reg  [5:0]  owed;
  reg  [5:0]  ahead;
  reg         err_cmd;
  reg         aw_hold;
  reg         w_hold;
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;
  wire [7:0]  bank_open;
  wire [7:0]  bank_rdy;
  wire [2:0]  op    = cmd_reg[2:0];
  wire [2:0]  bnk   = cmd_reg[6:4];
  wire        cmd_a10 = cmd_reg[8];
  wire        cmd_bg0 = cmd_reg[9];
  wire [5:0]  post_max = (fgr_mode == `RAPR_FGR_4X) ? 6'h20 :
                         (fgr_mode == `RAPR_FGR_2X) ? 6'h10 : `RAPR_POST_1X;
  wire        all_idle = (bank_open == 8'h00) && (bank_rdy == 8'hFF);
  wire        faw_ok   = (faw_cnt[faw_ptr] == 8'h00);
  wire        same_bg  = (bnk[2:1] == last_bg);
  // Spacing limit picked by the group of the activate about to go out
  wire        act_ok   = faw_ok && (rrd_cnt >= (same_bg ? T_RRDL[7:0] : T_RRDS[7:0])) &&
                         !bank_open[bnk] && bank_rdy[bnk];
  wire        ref_due  = (owed == post_max);
  wire        refi_end = (refi_cnt == T_REFI[15:0] - 16'h0001);
  wire        host_ref = cmd_pend && (op == `RAPR_OP_REF);
  wire        go_act, go_pre, go_prea, go_ref, go_rw, go_bad;
  // ****************************************************************
  // Command legality checks
  // ****************************************************************
  assign go_act  = (state == S_IDLE) && cmd_pend && op == `RAPR_OP_ACT && act_ok && !ref_due;
  assign go_pre  = (state == S_IDLE) && cmd_pend && op == `RAPR_OP_PRE;
  assign go_prea = (state == S_IDLE) && cmd_pend && op == `RAPR_OP_PREA;
  assign go_rw   = (state == S_IDLE) && cmd_pend && (op == `RAPR_OP_RD || op == `RAPR_OP_WR)
                   && bank_open[bnk] && !ref_due;
  assign go_ref  = (state == S_IDLE) && all_idle && (ref_due || (auto_ref && owed != 6'h00) ||
                   (cmd_pend && op == `RAPR_OP_REF && ahead < post_max));
  // Unknown ops are dropped and flagged
  assign go_bad  = (state == S_IDLE) && cmd_pend &&
                   (op == 3'h0 || op == 3'h7 || (op == `RAPR_OP_REF && ahead >= post_max));

  rapr_bank_timer #(.NB(8), .TRP(T_RP)) u_bank (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .act_i   (go_act && !go_ref),
    .pre_i   ((go_pre || (go_rw && cmd_a10)) && !go_ref),
    .prea_i  (go_prea && !go_ref),
    .ref_i   (go_ref),
    .bank_i  (bnk),
    .open_o  (bank_open),
    .ready_o (bank_rdy)
  );

  // ****************************************************************
  // Command pins and sequencing
  // ****************************************************************
  // Refresh wins over host command; at the postpone limit a due refresh still waits for the host to close open banks
  always @(posedge clk_i) begin
    if (srst_i) begin
      state <= S_IDLE;
      {cs_n_o, act_n_o, ras_n_o, cas_n_o, we_n_o} <= 5'h1F;
      bg_o    <= 2'h0;
      ba_o    <= 2'h0;
      addr_o  <= 18'h00000;
      rfc_cnt <= 16'h0000;
    end else begin
      {cs_n_o, act_n_o, ras_n_o, cas_n_o, we_n_o} <= 5'h1F; // Deselect by default
      case (state)
        S_IDLE: begin
          if (go_ref) begin
            {cs_n_o, act_n_o, ras_n_o, cas_n_o, we_n_o} <= 5'b01001;
            // Only a host refresh carries a rate choice; stale command bits must not leak
            bg_o    <= {1'b0, cmd_bg0 & fgr_mode[2] & host_ref};
            rfc_cnt <= T_RFC[15:0];
            state   <= S_RFC;
          end else if (go_act) begin
            {cs_n_o, act_n_o} <= 2'b00;
            {ras_n_o, cas_n_o, we_n_o} <= {row_reg[16], row_reg[15], row_reg[14]};
            bg_o   <= bnk[2:1];
            ba_o   <= {1'b0, bnk[0]};
            addr_o <= row_reg;
          end else if (go_pre || go_prea) begin
            {cs_n_o, act_n_o, ras_n_o, cas_n_o, we_n_o} <= 5'b01010;
            bg_o   <= bnk[2:1];
            ba_o   <= {1'b0, bnk[0]};
            addr_o <= {7'h00, go_prea, 10'h000};
          end else if (go_rw) begin
            {cs_n_o, act_n_o, ras_n_o, cas_n_o, we_n_o} <= {4'b0110, op != `RAPR_OP_WR};
            bg_o   <= bnk[2:1];
            ba_o   <= {1'b0, bnk[0]};
            addr_o <= {7'h00, cmd_a10, 10'h000};
          end
        end
        S_RFC: begin
          // Only deselects until refresh cycle ends
          if (rfc_cnt <= 16'h0001) state <= S_IDLE;
          rfc_cnt <= rfc_cnt - 16'h0001;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Activate spacing and four-activate window
  // ****************************************************************
  always @(posedge clk_i) begin : p_act
    integer i;
    if (srst_i) begin
      rrd_cnt <= 8'hFF;
      last_bg <= 2'h0;
      faw_ptr <= 2'h0;
      for (i = 0; i < 4; i = i + 1) faw_cnt[i] <= 8'h00;
    end else begin
      for (i = 0; i < 4; i = i + 1)
        if (faw_cnt[i] != 8'h00) faw_cnt[i] <= faw_cnt[i] - 8'h01;
      // Counts up from the last activate and saturates above any spacing
      if (rrd_cnt != 8'hFF) rrd_cnt <= rrd_cnt + 8'h01;
      if (go_act && !go_ref) begin
        rrd_cnt <= 8'h01;
        last_bg <= bnk[2:1];
        faw_cnt[faw_ptr] <= T_FAW[7:0] - 8'h01;
        faw_ptr <= faw_ptr + 2'h1;
      end
    end
  end

  // ****************************************************************
  // Refresh debt: owed intervals and pull-ins
  // ****************************************************************
  always @(posedge clk_i) begin
    if (srst_i) begin
      refi_cnt <= 16'h0000;
      owed     <= 6'h00;
      ahead    <= 6'h00;
    end else begin
      refi_cnt <= refi_end ? 16'h0000 : refi_cnt + 16'h0001;
      // An interval end and a refresh in one cycle cancel; none may be lost
      if (refi_end && !go_ref) begin
        if (ahead != 6'h00) ahead <= ahead - 6'h01;
        else if (owed < post_max) owed <= owed + 6'h01;
      end else if (go_ref && !refi_end) begin
        if (owed != 6'h00) owed <= owed - 6'h01;
        else ahead <= ahead + 6'h01;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  // Write address and data may arrive in either order
  always @(posedge clk_i) begin
    if (srst_i) begin
      s_awready_o <= 1'b0;
      s_wready_o  <= 1'b0;
      s_bvalid_o  <= 1'b0;
      s_bresp_o   <= `RAPR_OK;
      aw_hold     <= 1'b0;
      w_hold      <= 1'b0;
      aw_addr     <= 8'h00;
      w_data      <= 32'h0;
      fgr_mode    <= `RAPR_FGR_1X;
      auto_ref    <= 1'b1;
      cmd_reg     <= 32'h0;
      cmd_pend    <= 1'b0;
      row_reg     <= 18'h00000;
      err_cmd     <= 1'b0;
    end else begin
      s_awready_o <= !aw_hold && s_awvalid_i && !s_awready_o && !s_bvalid_o;
      s_wready_o  <= !w_hold && s_wvalid_i && !s_wready_o && !s_bvalid_o;
      if (s_awvalid_i && s_awready_o) begin
        aw_hold <= 1'b1;
        aw_addr <= s_awaddr_i;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_hold <= 1'b1;
        w_data <= s_wdata_i;
      end
      if (go_act || go_pre || go_prea || go_rw || go_bad || (go_ref && op == `RAPR_OP_REF && cmd_pend))
        cmd_pend <= go_ref && op != `RAPR_OP_REF; // Refresh preempted a host command
      if (go_bad) err_cmd <= 1'b1;
      if (aw_hold && w_hold && !s_bvalid_o) begin
        aw_hold    <= 1'b0;
        w_hold     <= 1'b0;
        s_bvalid_o <= 1'b1;
        s_bresp_o  <= `RAPR_OK;
        case (aw_addr)
          `RAPR_REG_CTRL: begin
            fgr_mode <= w_data[2:0];
            auto_ref <= w_data[4];
            // A refusal in the same cycle keeps the flag: set beats clear
            if (w_data[8] && !go_bad) err_cmd <= 1'b0;
          end
          `RAPR_REG_CMD: begin
            if (!cmd_pend) begin
              cmd_reg  <= w_data;
              cmd_pend <= 1'b1;
            end
          end
          `RAPR_REG_ROW:  row_reg <= w_data[17:0];
          default:        s_bresp_o <= `RAPR_SLVERR;
        endcase
      end else if (s_bvalid_o && s_bready_i) s_bvalid_o <= 1'b0;
    end
  end

  // Read channel; capability word latched every cycle
  always @(posedge clk_i) begin
    if (srst_i) begin
      s_arready_o <= 1'b0;
      s_rvalid_o  <= 1'b0;
      s_rdata_o   <= 32'h0;
      s_rresp_o   <= `RAPR_OK;
      mac_reg <= 8'h00;
    end else begin
      mac_reg     <= mac_code_i;
      s_arready_o <= s_arvalid_i && !s_arready_o && !s_rvalid_o;
      if (s_arvalid_i && s_arready_o) begin
        s_rvalid_o <= 1'b1;
        s_rresp_o  <= `RAPR_OK;
        s_rdata_o  <= 32'h0;
        case (s_araddr_i)
          `RAPR_REG_CTRL:   s_rdata_o <= {27'h0, auto_ref, 1'b0, fgr_mode};
          `RAPR_REG_CMD:    s_rdata_o <= cmd_reg;
          `RAPR_REG_ROW:    s_rdata_o <= {14'h0, row_reg};
          `RAPR_REG_STATUS: s_rdata_o <= {10'h0, ahead, 2'h0, owed, 5'h0, err_cmd, state == S_RFC, cmd_pend};
          // Unlimited flag saves software decoding; finite limits are software's to police
          `RAPR_REG_MAC:    s_rdata_o <= {23'h0, mac_reg[3:0] == `RAPR_MAC_UNLIM, mac_reg};
          `RAPR_REG_OPEN:   s_rdata_o <= {16'h0, bank_rdy, bank_open};
          default:          s_rresp_o <= `RAPR_SLVERR;
        endcase
      end else if (s_rvalid_o && s_rready_i) s_rvalid_o <= 1'b0;
    end
  end
endmodule // rapr_ctrl

// file: tb/rapr_dev_model.sv
// Behavioural model of the memory device on the command pins.
// Assumes commands are sampled on rising clk_i, one per cycle.
`timescale 1ns/1ps
module rapr_dev_model (
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire        cs_n_i,
  input  wire        act_n_i,
  input  wire        ras_n_i,
  input  wire        cas_n_i,
  input  wire        we_n_i,
  input  wire [1:0]  bg_i,
  input  wire [1:0]  ba_i,
  input  wire [17:0] addr_i,
  input  wire [7:0]  code_i,
  output wire [7:0]  mac_code_o,
  output reg  [17:0] row_o,
  output reg  [2:0]  bank_o,
  output reg  [15:0] ref_cnt_o,
  output reg         ref_bg0_o,
  output reg  [7:0]  open_o
);
  wire [2:0] bk = {bg_i, ba_i[0]};
  // Readout word 3, upper nibble is don't-care
  assign mac_code_o = code_i;
  // Command decode; victim rows are refreshed internally, no host help
  always @(posedge clk_i) begin
    if (srst_i) begin
      open_o <= 8'h00;
      ref_cnt_o <= 16'h0000;
      ref_bg0_o <= 1'b0;
    end else if (!cs_n_i) begin
      if (!act_n_i) begin
        row_o <= {addr_i[17], ras_n_i, cas_n_i, we_n_i, addr_i[13:0]};
        bank_o <= bk;
        open_o[bk] <= 1'b1;
      end else if (!ras_n_i && cas_n_i && !we_n_i) begin
        if (addr_i[10]) open_o <= 8'h00;
        else open_o[bk] <= 1'b0;
      end else if (!ras_n_i && !cas_n_i && we_n_i) begin
        ref_cnt_o <= ref_cnt_o + 16'h0001;
        ref_bg0_o <= bg_i[0];
        open_o <= 8'h00;
      end else if (ras_n_i && !cas_n_i && addr_i[10]) begin
        open_o[bk] <= 1'b0;
      end
    end
  end
endmodule // rapr_dev_model

// file: tb/rapr_monitor.sv
// Command pin checker for the host controller.
// Assumes bound into rapr_ctrl and fed its timing parameters.
`timescale 1ns/1ps
module rapr_monitor #(
  parameter T_RRDS = 4,
  parameter T_RRDL = 6,
  parameter T_FAW  = 21,
  parameter T_RP   = 14,
  parameter T_RFC  = 35,
  parameter T_REFI = 780
) (
  input wire        clk_i,
  input wire        srst_i,
  input wire        cs_n_o,
  input wire        act_n_o,
  input wire        ras_n_o,
  input wire        cas_n_o,
  input wire        we_n_o,
  input wire [1:0]  bg_o,
  input wire [1:0]  ba_o,
  input wire [17:0] addr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire       cmd = !cs_n_o;
  wire       act = cmd && !act_n_o;
  wire       c2  = cmd && act_n_o;
  wire       pre = c2 && !ras_n_o && cas_n_o && !we_n_o;
  wire       rfs = c2 && !ras_n_o && !cas_n_o && we_n_o;
  wire       rw  = c2 && ras_n_o && !cas_n_o;
  wire [2:0] bk  = {bg_o, ba_o[0]};
  int         since_act, since_ref, since_pre[8];
  logic [1:0] last_bg;
  logic [7:0] opn;
  logic [T_FAW-2:0] hist;
  logic       all_rp;
  // Cycle counters since last activate, refresh and per-bank close
  always @(posedge clk_i) begin
    if (srst_i) begin
      since_act <= 1000;
      since_ref <= T_RFC;
      opn <= 8'h00;
      hist <= '0;
      last_bg <= 2'h0;
      for (int i = 0; i < 8; i++) since_pre[i] <= T_RP;
    end else begin
      since_act <= act ? 1 : since_act + 1;
      since_ref <= rfs ? 1 : since_ref + 1;
      hist <= {hist[T_FAW-3:0], act};
      if (act) last_bg <= bg_o;
      if (act) opn[bk] <= 1'b1;
      for (int i = 0; i < 8; i++) begin
        since_pre[i] <= since_pre[i] + 1;
        // Auto precharge counted from the access, the earliest it can start
        if ((pre && (addr_o[10] || bk == i)) || (rw && addr_o[10] && bk == i)) begin
          since_pre[i] <= 1;
          opn[i] <= 1'b0;
        end
      end
    end
  end
  // All banks past row precharge time
  always_comb begin
    all_rp = 1'b1;
    for (int i = 0; i < 8; i++) if (since_pre[i] < T_RP) all_rp = 1'b0;
  end
  cmd_one_cycle_a: assert property (cmd |=> cs_n_o) else $error("command held past one cycle");
  rrd_spacing_a: assert property (
    act |-> since_act >= ((bg_o == last_bg) ? T_RRDL : T_RRDS)) else $error("activate spacing too short");
  faw_window_a: assert property (act |-> $countones(hist) <= 3) else $error("fifth activate in window");
  act_idle_bank_a: assert property (act |-> !opn[bk]) else $error("activate to open bank");
  act_trp_wait_a: assert property (act |-> since_pre[bk] >= T_RP) else $error("activate before precharge time");
  rdwr_open_bank_a: assert property (rw |-> opn[bk]) else $error("access to idle bank");
  ref_idle_banks_a: assert property (rfs |-> opn == 8'h00 && all_rp) else $error("refresh with bank busy");
  rfc_deselect_a: assert property (cmd |-> since_ref >= T_RFC) else $error("command inside refresh cycle");
  ref_gap_limit_a: assert property (since_ref <= 9 * T_REFI + T_RFC) else $error("refresh gap too long");
endmodule // rapr_monitor
bind rapr_ctrl rapr_monitor #(.T_RRDS(T_RRDS), .T_RRDL(T_RRDL), .T_FAW(T_FAW), .T_RP(T_RP), .T_RFC(T_RFC),
  .T_REFI(T_REFI)) u_mon (.clk_i, .srst_i, .cs_n_o, .act_n_o, .ras_n_o, .cas_n_o, .we_n_o, .bg_o, .ba_o, .addr_o);

// file: tb/testbench.sv
// Self-checking bench for the host controller with a device model.
// Assumes AXI4-Lite register map and command codes from rapr_defs.vh.
`timescale 1ns/1ps
`include "rapr_defs.vh"
module testbench;
  localparam T_REFI = 2000;
  logic [7:0]  s_awaddr_i, s_araddr_i, code;
  logic [31:0] s_wdata_i, d, row;
  logic        clk_i, srst_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i;
  logic [3:0]  s_wstrb_i;
  logic [1:0]  rsp;
  wire         s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, mbg0;
  wire         cs_n_o, act_n_o, ras_n_o, cas_n_o, we_n_o;
  wire [1:0]   s_bresp_o, s_rresp_o, bg_o, ba_o;
  wire [31:0]  s_rdata_o;
  wire [17:0]  addr_o, mrow;
  wire [7:0]   mac_code_i, mopen;
  wire [2:0]   mbank;
  wire [15:0]  mref;
  integer      n_errors = 0, compares = 0, seed = 12562, i, b;
  // Lengthened timings make spacing rules bind against bus overhead
  rapr_ctrl #(.T_RRDS(12), .T_RRDL(20), .T_FAW(80), .T_RP(30), .T_RFC(35), .T_REFI(T_REFI)) dut (
    .clk_i, .srst_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wdata_i, .s_wstrb_i, .s_wvalid_i,
    .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i, .s_arvalid_i, .s_arready_o,
    .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i, .mac_code_i, .cs_n_o, .act_n_o, .ras_n_o,
    .cas_n_o, .we_n_o, .bg_o, .ba_o, .addr_o);
  rapr_dev_model u_dev (.clk_i, .srst_i, .cs_n_i(cs_n_o), .act_n_i(act_n_o), .ras_n_i(ras_n_o),
    .cas_n_i(cas_n_o), .we_n_i(we_n_o), .bg_i(bg_o), .ba_i(ba_o), .addr_i(addr_o), .code_i(code),
    .mac_code_o(mac_code_i), .row_o(mrow), .bank_o(mbank), .ref_cnt_o(mref), .ref_bg0_o(mbg0), .open_o(mopen));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  function automatic [31:0] exp_mac(input [7:0] c);
    exp_mac = {23'h0, c[3:0] == 4'h8, c};
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task axw(input [7:0] a, input [31:0] v);
    @(posedge clk_i);
    s_awaddr_i <= a;
    s_wdata_i <= v;
    s_awvalid_i <= 1'b1;
    s_wvalid_i <= 1'b1;
    s_bready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_awready_o) s_awvalid_i <= 1'b0;
      if (s_wready_o) s_wvalid_i <= 1'b0;
    end while (s_bvalid_o !== 1'b1);
    rsp = s_bresp_o;
    s_bready_i <= 1'b0;
  endtask
  task axr(input [7:0] a);
    @(posedge clk_i);
    s_araddr_i <= a;
    s_arvalid_i <= 1'b1;
    s_rready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_arready_o) s_arvalid_i <= 1'b0;
    end while (s_rvalid_o !== 1'b1);
    d = s_rdata_o;
    rsp = s_rresp_o;
    s_rready_i <= 1'b0;
  endtask
  // Post a command, then poll until it and any refresh cycle are done
  task cmd(input [2:0] op, input [2:0] bk, input ap, input otf, input [17:0] r);
    axw(`RAPR_REG_ROW, {14'h0, r});
    axw(`RAPR_REG_CMD, {22'h0, otf, ap, 1'b0, bk, 1'b0, op});
    do axr(`RAPR_REG_STATUS); while (d[1:0] !== 2'b00);
  endtask
  task report_and_stop;
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Generous bound: the sequence needs well under a tenth of it
  initial begin
    #1000000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    {srst_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i} = 6'b100000;
    {s_awaddr_i, s_araddr_i, code, s_wdata_i, s_wstrb_i} = {24'h0, 32'h0, 4'hF};
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    axr(`RAPR_REG_CTRL);
    chk("ctrl reset", 32'h10, d);
    axr(`RAPR_REG_STATUS);
    chk("status reset", 32'h0, d);
    axr(8'h18);
    chk("unmapped rresp", `RAPR_SLVERR, rsp);
    chk("unmapped rdata", 32'h0, d);
    axw(8'h18, 32'h5A5A5A5A);
    chk("unmapped bresp", `RAPR_SLVERR, rsp);
    // Every limit code, reserved ones too, with random upper bits
    for (i = 0; i < 16; i++) begin
      b = $random(seed);
      code <= {b[7:4], i[3:0]};
      axr(`RAPR_REG_MAC);
      chk("mac word", exp_mac({b[7:4], i[3:0]}), d);
    end
    // Random rows: open, access, close explicitly or by auto precharge
    for (i = 0; i < 6; i++) begin
      b = $random(seed);
      row = $random(seed);
      cmd(`RAPR_OP_ACT, b[2:0], 1'b0, 1'b0, row[17:0]);
      chk("act row", row[17:0], mrow);
      chk("act bank", b[2:0], mbank);
      cmd(i[0] ? `RAPR_OP_WR : `RAPR_OP_RD, b[2:0], i[0], 1'b0, row[17:0]);
      if (!i[0]) cmd(`RAPR_OP_PRE, b[2:0], 1'b0, 1'b0, 18'h0);
      axr(`RAPR_REG_OPEN);
      chk("bank closed", 1'b0, d[b[2:0]]);
    end
    // Five activates back to back, both within and across groups
    for (i = 0; i < 5; i++) cmd(`RAPR_OP_ACT, i[2:0], 1'b0, 1'b0, 18'h3FFFF - i[17:0]);
    chk("open banks", 8'h1F, mopen);
    cmd(`RAPR_OP_PREA, 3'h0, 1'b0, 1'b0, 18'h0);
    cmd(`RAPR_OP_ACT, 3'h0, 1'b0, 1'b0, 18'h2AAAA);
    cmd(`RAPR_OP_PRE, 3'h0, 1'b0, 1'b0, 18'h0);
    cmd(`RAPR_OP_PRE, 3'h0, 1'b0, 1'b0, 18'h0);
    axr(`RAPR_REG_OPEN);
    chk("all closed", 8'h00, d[7:0]);
    // On-the-fly refresh selects the finer rate through group bit 0
    axw(`RAPR_REG_CTRL, {24'h0, 5'h02, `RAPR_FGR_OTF2});
    cmd(`RAPR_OP_REF, 3'h0, 1'b0, 1'b1, 18'h0);
    chk("otf bg0", 1'b1, mbg0);
    axw(`RAPR_REG_CTRL, 32'h10);
    // Pull-ins beyond the maximum earn nothing and flag an error
    for (i = 0; i < 10; i++) cmd(`RAPR_OP_REF, 3'h0, 1'b0, 1'b0, 18'h0);
    axr(`RAPR_REG_STATUS);
    chk("pulled in", `RAPR_POST_1X, d[21:16]);
    chk("pull error", 1'b1, d[2]);
    chk("ref count", `RAPR_POST_1X, mref);
    chk("ref idle", 8'h00, mopen);
    axw(`RAPR_REG_CTRL, 32'h110);
    axr(`RAPR_REG_STATUS);
    chk("error cleared", 1'b0, d[2]);
    report_and_stop;
  end
endmodule // testbench
